// ---- inc/qpc_defines.svh ----
/*
 * Offsets, field positions and fixed figures of the
 * quadrature pulse counter.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH

`define QPC_AW 8
`define QPC_CNT_W 16
`define QPC_FILT_DEPTH 4

`define QPC_ADDR_CTRL 8'h00
`define QPC_ADDR_STATUS 8'h04
`define QPC_ADDR_COUNT 8'h08
`define QPC_ADDR_MAXC 8'h0C
`define QPC_ADDR_LATCH 8'h10

`define QPC_CTRL_EN 0
`define QPC_CTRL_MODE_LO 1
`define QPC_CTRL_MODE_HI 2
`define QPC_CTRL_FEN 3

`define QPC_ST_WRAP 0
`define QPC_ST_DCHG 1
`define QPC_ST_DIR 2

`define QPC_MODE_X2_BIT 0
`define QPC_MODE_CMP_BIT 1

`define QPC_FREE_LIMIT 16'hFFFF
`define QPC_CNT_ZERO 16'h0000

`endif

// ---- inc/qpc_pkg.sv ----
/*
 * Types of the quadrature pulse counter: count modes and module state.
 * Assumes qpc_defines.svh is on the include path.
 */
`include "qpc_defines.svh"

package qpc_pkg;

  typedef enum logic [1:0] {
    QPC_X4_FREE = 2'h0,
    QPC_X2_FREE = 2'h1,
    QPC_X4_CMP = 2'h2,
    QPC_X2_CMP = 2'h3
  } qpc_mode_t;

  typedef struct packed {
    logic [`QPC_FILT_DEPTH-1:0] hist;
    logic level;
  } qpc_filt_t;

  typedef struct packed {
    logic [`QPC_CNT_W-1:0] cnt;
    logic [`QPC_CNT_W-1:0] maxc;
    logic [`QPC_CNT_W-1:0] latch_buf;
    logic en;
    qpc_mode_t mode;
    logic fen;
    logic dir;
    logic wrap_f;
    logic dchg_f;
    logic a_q;
    logic b_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } qpc_state_t;

endpackage

// ---- rtl/qpc_filter.sv ----
/*
 * Noise filter for one encoder phase: a new level is passed on only after
 * four identical samples in a row; when disabled the raw level passes after
 * one flop.
 * Assumes the raw input is synchronous to the system clock.
 */
`timescale 1ns/1ps
`include "qpc_defines.svh"

module qpc_filter
  import qpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  input wire logic fen_i,
  output logic level_o
);

  qpc_filt_t st_r;
  qpc_filt_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hist = {st_r.hist[`QPC_FILT_DEPTH-2:0], raw_i};
    if (!fen_i) begin
      st_nxt.level = raw_i;
    end else if (&st_nxt.hist) begin
      st_nxt.level = 1'b1;
    end else if (~|st_nxt.hist) begin
      st_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

  property filt_rise_p;
    @(posedge clk_i) disable iff (rst_i)
      ($rose(st_r.level) && $past(fen_i)) |->
        ($past(raw_i, 1) && $past(raw_i, 2) && $past(raw_i, 3) && $past(raw_i, 4));
  endproperty
  filt_rise_a: assert property (filt_rise_p) else $error("filtered rise without 4 samples");

  filt_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(st_r.level) && $past(fen_i)) |->
      (!$past(raw_i, 1) && !$past(raw_i, 2) && !$past(raw_i, 3) && !$past(raw_i, 4)))
    else $error("filtered fall without 4 samples");

endmodule // qpc_filter

// ---- rtl/qpc_top.sv ----
/*
 * Quadrature encoder decoder with 16-bit up/down pulse counter, compare
 * limit, wrap and direction-change flags, and an APB register slave.
 * Assumes encoder inputs synchronous to SYS_CLK_I (20 MHz) and a
 * zero-wait APB master.
 */
`timescale 1ns/1ps
`include "qpc_defines.svh"

// Overview of operation
// - free mode counts per direction; wrap flag on overflow or underflow
// - compare mode up: limit to zero sets wrap flag on active edge
// - compare mode down: zero to limit sets wrap flag on active edge
// - x2: count one per A edge; B edges only steer direction
// - x4: count one per edge of either phase
// - A leading gives direction 1 and increments; lagging gives 0, decrements
// - direction from current edge against other phase's previous edge
// - mode codes 00 and 10 select x4
// - mode codes 01 and 11 select x2, A edges only clock counter
// - free up: 65535 then next forward edge gives zero and wrap flag
// - wrap flag set by hardware only, cleared by software
// - turning to down count clears direction and sets direction-change flag
// - down from zero reloads 65535 free, or limit in compare mode
// - x2 only A edges set wrap; x4 either phase
// - counter unchanged on mode change or while disabled
// - enabled filter needs 4 identical samples for an edge
// - capture pin zero is phase A, capture pin one phase B
// - count readable through a 16-bit latched buffer
module qpc_top
  import qpc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CAPTURE_PIN_ZERO_I,
  input wire logic CAPTURE_PIN_ONE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`QPC_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic DIR_O,
  output logic WRAP_FLAG_O,
  output logic DIR_CHANGE_FLAG_O
);

  qpc_state_t st_r;
  qpc_state_t st_nxt;
  logic filtered_phase_a;
  logic filtered_phase_b;
  logic edge_a;
  logic edge_b;
  logic active_edge;
  logic count_up;
  logic cmp_mode;
  logic x2_mode;
  logic [`QPC_CNT_W-1:0] limit;
  logic acc_wr;
  logic cnt_wr;
  logic status_wr;
  logic wrap_evt;

  qpc_filter u_filt_a (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .raw_i(CAPTURE_PIN_ZERO_I),
    .fen_i(st_r.fen),
    .level_o(filtered_phase_a)
  );

  qpc_filter u_filt_b (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .raw_i(CAPTURE_PIN_ONE_I),
    .fen_i(st_r.fen),
    .level_o(filtered_phase_b)
  );

  function automatic logic addr_ok(input logic [`QPC_AW-1:0] a);
    addr_ok = (a == `QPC_ADDR_CTRL) || (a == `QPC_ADDR_STATUS) ||
              (a == `QPC_ADDR_COUNT) || (a == `QPC_ADDR_MAXC) ||
              (a == `QPC_ADDR_LATCH);
  endfunction

  function automatic logic [31:0] rd_mux(input qpc_state_t s, input logic [`QPC_AW-1:0] a);
    rd_mux = '0;
    case (a)
      `QPC_ADDR_CTRL: begin
        rd_mux[`QPC_CTRL_EN] = s.en;
        rd_mux[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO] = s.mode;
        rd_mux[`QPC_CTRL_FEN] = s.fen;
      end
      `QPC_ADDR_STATUS: begin
        rd_mux[`QPC_ST_WRAP] = s.wrap_f;
        rd_mux[`QPC_ST_DCHG] = s.dchg_f;
        rd_mux[`QPC_ST_DIR] = s.dir;
      end
      `QPC_ADDR_COUNT: rd_mux[`QPC_CNT_W-1:0] = s.cnt;
      `QPC_ADDR_MAXC: rd_mux[`QPC_CNT_W-1:0] = s.maxc;
      `QPC_ADDR_LATCH: rd_mux[`QPC_CNT_W-1:0] = s.latch_buf;
      default: rd_mux = '0;
    endcase
  endfunction

  // edges are seen against the previous filtered level
  assign edge_a = filtered_phase_a ^ st_r.a_q;
  assign edge_b = filtered_phase_b ^ st_r.b_q;
  assign cmp_mode = st_r.mode[`QPC_MODE_CMP_BIT];
  assign x2_mode = st_r.mode[`QPC_MODE_X2_BIT];
  assign limit = cmp_mode ? st_r.maxc : `QPC_FREE_LIMIT;
  // A edge: up when new A differs from B; B edge: up when new B equals A
  assign count_up = edge_a ? (filtered_phase_a ^ filtered_phase_b)
                           : (filtered_phase_a ~^ filtered_phase_b);
  // simultaneous edges break the encoder spacing; the A edge then decides
  assign active_edge = st_r.en && (edge_a || (!x2_mode && edge_b));
  assign acc_wr = PSEL_I && PENABLE_I && st_r.pready && PWRITE_I;
  assign cnt_wr = acc_wr && (PADDR_I == `QPC_ADDR_COUNT);
  assign status_wr = acc_wr && (PADDR_I == `QPC_ADDR_STATUS);
  // a wrap is due on this edge; only the checks below read it
  assign wrap_evt = active_edge && !cnt_wr &&
                    (count_up ? (st_r.cnt == limit) : (st_r.cnt == `QPC_CNT_ZERO));

  always_comb begin
    st_nxt = st_r;
    st_nxt.a_q = filtered_phase_a;
    st_nxt.b_q = filtered_phase_b;
    st_nxt.latch_buf = st_r.cnt;
    // bus: reply prepared in setup, access phase completes in one cycle
    st_nxt.pready = PSEL_I && !PENABLE_I;
    st_nxt.pslverr = PSEL_I && !PENABLE_I && !addr_ok(PADDR_I);
    st_nxt.prdata = (PSEL_I && !PENABLE_I && !PWRITE_I) ? rd_mux(st_r, PADDR_I) : '0;
    // software side first so that hardware sets below win
    if (acc_wr) begin
      case (PADDR_I)
        `QPC_ADDR_CTRL: begin
          st_nxt.en = PWDATA_I[`QPC_CTRL_EN];
          st_nxt.mode = qpc_mode_t'(PWDATA_I[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO]);
          st_nxt.fen = PWDATA_I[`QPC_CTRL_FEN];
        end
        `QPC_ADDR_STATUS: begin
          if (PWDATA_I[`QPC_ST_WRAP]) begin
            st_nxt.wrap_f = 1'b0;
          end
          if (PWDATA_I[`QPC_ST_DCHG]) begin
            st_nxt.dchg_f = 1'b0;
          end
        end
        `QPC_ADDR_COUNT: st_nxt.cnt = PWDATA_I[`QPC_CNT_W-1:0];
        `QPC_ADDR_MAXC: st_nxt.maxc = PWDATA_I[`QPC_CNT_W-1:0];
        default: st_nxt.en = st_r.en;
      endcase
    end
    if (st_r.en && (edge_a || edge_b)) begin
      st_nxt.dir = count_up;
      if (st_r.dir && !count_up) begin
        st_nxt.dchg_f = 1'b1;
      end
    end
    // a software count write in the same cycle overrides the edge
    if (active_edge && !cnt_wr) begin
      if (count_up) begin
        if (st_r.cnt == limit) begin
          st_nxt.cnt = `QPC_CNT_ZERO;
          st_nxt.wrap_f = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end else begin
        if (st_r.cnt == `QPC_CNT_ZERO) begin
          st_nxt.cnt = limit;
          st_nxt.wrap_f = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
    end
  end

  // counter only moves on active edges or count writes, so disable or mode change keep it
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA_O = st_r.prdata;
  assign PREADY_O = st_r.pready;
  assign PSLVERR_O = st_r.pslverr;
  assign DIR_O = st_r.dir;
  assign WRAP_FLAG_O = st_r.wrap_f;
  assign DIR_CHANGE_FLAG_O = st_r.dchg_f;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  count_step_a: assert property (
    (active_edge && count_up && !cnt_wr && st_r.cnt != limit) |=>
      (st_r.cnt == $past(st_r.cnt) + 16'h0001))
    else $error("counter did not step up by one");

  up_wrap_a: assert property (
    (active_edge && count_up && !cnt_wr && st_r.cnt == limit) |=>
      (st_r.cnt == `QPC_CNT_ZERO && st_r.wrap_f))
    else $error("up wrap missed");

  down_wrap_a: assert property (
    (active_edge && !count_up && !cnt_wr && st_r.cnt == `QPC_CNT_ZERO) |=>
      (st_r.cnt == $past(limit) && st_r.wrap_f))
    else $error("down reload missed");

  free_limit_a: assert property (
    (!cmp_mode && active_edge && !count_up && !cnt_wr && st_r.cnt == `QPC_CNT_ZERO) |=>
      (st_r.cnt == `QPC_FREE_LIMIT))
    else $error("free mode did not reload full scale");

  x2_ignore_b_a: assert property (
    (x2_mode && edge_b && !edge_a && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("x2 counted a phase B edge");

  x4_b_counts_a: assert property (
    (st_r.en && !x2_mode && edge_b && !edge_a && !cnt_wr) |=>
      (!$stable(st_r.cnt) || ($past(limit) == `QPC_CNT_ZERO && st_r.wrap_f)))
    else $error("x4 ignored a phase B edge");

  dir_from_a_a: assert property (
    (st_r.en && edge_a) |=> (st_r.dir == ($past(filtered_phase_a) ^ $past(filtered_phase_b))))
    else $error("direction wrong on phase A edge");

  dir_change_a: assert property (
    (st_r.en && st_r.dir && (edge_a || edge_b) && !count_up) |=> (!st_r.dir && st_r.dchg_f))
    else $error("direction change not flagged");

  wrap_sticky_a: assert property (
    (st_r.wrap_f && !(status_wr && PWDATA_I[`QPC_ST_WRAP])) |=> st_r.wrap_f)
    else $error("wrap flag cleared without software");

  wrap_source_a: assert property (
    $rose(st_r.wrap_f) |-> $past(active_edge))
    else $error("wrap flag set without active edge");

  hold_count_a: assert property (
    (!st_r.en && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("counter moved while disabled");

  latch_buf_a: assert property (
    1'b1 |=> (st_r.latch_buf == $past(st_r.cnt)))
    else $error("latched buffer lags");

  down_step_a: assert property (
    (active_edge && !count_up && !cnt_wr && st_r.cnt != `QPC_CNT_ZERO) |=>
      (st_r.cnt == $past(st_r.cnt) - 16'h0001))
    else $error("counter did not step down by one");

  dir_from_b_a: assert property (
    (st_r.en && edge_b && !edge_a) |=>
      (st_r.dir == ($past(filtered_phase_a) ~^ $past(filtered_phase_b))))
    else $error("direction wrong on phase B edge");

  dchg_sticky_a: assert property (
    (st_r.dchg_f && !(status_wr && PWDATA_I[`QPC_ST_DCHG])) |=> st_r.dchg_f)
    else $error("direction-change flag cleared without software");

  set_wins_a: assert property (
    (wrap_evt && status_wr && PWDATA_I[`QPC_ST_WRAP]) |=> st_r.wrap_f)
    else $error("software clear beat a wrap");

  x2_wrap_src_a: assert property (
    ($rose(st_r.wrap_f) && $past(x2_mode)) |-> $past(edge_a))
    else $error("x2 wrap set by phase B");

  mode_keep_a: assert property (
    (acc_wr && PADDR_I == `QPC_ADDR_CTRL && !active_edge) |=> $stable(st_r.cnt))
    else $error("control write moved the counter");

  // bus checks: the slave never stretches a transfer
  ready_pulse_a: assert property (
    (PSEL_I && !PENABLE_I) |=> PREADY_O)
    else $error("ready missing after setup");

  ready_once_a: assert property (
    (PREADY_O && PENABLE_I) |=> !PREADY_O)
    else $error("ready held past access");

  bad_addr_a: assert property (
    (PSEL_I && !PENABLE_I && !addr_ok(PADDR_I)) |=> PSLVERR_O)
    else $error("unmapped address not refused");

  up_wrap_c: cover property (active_edge && count_up && st_r.cnt == limit && cmp_mode);
  down_wrap_c: cover property (active_edge && !count_up && st_r.cnt == `QPC_CNT_ZERO);
  dir_change_c: cover property ($rose(st_r.dchg_f));
  x2_count_c: cover property (x2_mode && active_edge);
  cmp_down_wrap_c: cover property (cmp_mode && wrap_evt && !count_up);

endmodule // qpc_top

// ---- tb/qpc_encoder_model.sv ----
/*
 * Incremental shaft encoder model: moves one phase per request, then holds
 * both levels for hold_i clocks before taking the next request.
 * Assumes requests come only while idle, driven just after a rising edge.
 */
`timescale 1ns/1ps

module qpc_encoder_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic fwd_i,
  input wire logic [3:0] hold_i,
  output logic pha_o,
  output logic phb_o,
  output logic busy_o
);
  logic [3:0] wait_r;

  assign busy_o = wait_r != 4'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pha_o <= 1'b0;
      phb_o <= 1'b0;
      wait_r <= 4'h0;
    end else if (busy_o) begin
      wait_r <= wait_r - 4'h1;
    end else if (step_i) begin
      // one phase per step, so the two phases never edge together
      if (fwd_i ^ pha_o ^ phb_o) pha_o <= ~pha_o;
      else phb_o <= ~phb_o;
      wait_r <= hold_i;
    end
  end
endmodule // qpc_encoder_model

// ---- tb/qpc_tb_top.sv ----
/*
 * Self-checking bench: an integer model of the counter and flags is
 * compared with the design after every encoder step.
 * Assumes the APB slave answers in the cycle after setup.
 */
`timescale 1ns/1ps
`include "qpc_defines.svh"

module qpc_tb_top import qpc_pkg::*; ;
  logic clk, rst, psel, pen, pwr, st, fw, pa, pb, slverr, busy, a_pin, b_pin;
  logic pready, pslverr, dir_o, wrap_o, dchg_o, en, dir, wrap, dchg;
  logic [7:0] paddr;
  logic [31:0] pwd, rd, prdata, rnd;
  logic [3:0] hold;
  logic [1:0] mv;
  qpc_mode_t mode;
  int bad_count, n_checks, cnt, maxc;
  int exp_q[$];

  qpc_encoder_model enc (.clk_i(clk), .rst_i(rst), .step_i(st), .fwd_i(fw),
    .hold_i(hold), .pha_o(a_pin), .phb_o(b_pin), .busy_o(busy));
  qpc_top dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CAPTURE_PIN_ZERO_I(a_pin),
    .CAPTURE_PIN_ONE_I(b_pin), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DIR_O(dir_o), .WRAP_FLAG_O(wrap_o),
    .DIR_CHANGE_FLAG_O(dchg_o));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // position of a phase pair in the forward sequence 00, 10, 11, 01
  function automatic int ph(input logic a, input logic b);
    if (a) return b ? 2 : 1;
    return b ? 3 : 0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    tally_and_finish();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 16) hang();
  endtask

  task automatic model(input logic ea, input logic a, input logic b);
    logic inc;
    int lim;
    inc = (ph(a, b) == (ph(pa, pb) + 1) % 4);
    lim = mode[1] ? maxc : 65535;
    if (!en) return;
    if (dir && !inc) dchg = 1'b1;
    dir = inc;
    if (!ea && mode[0]) return;
    if (inc && cnt == lim) begin
      cnt = 0;
      wrap = 1'b1;
    end else if (!inc && cnt == 0) begin
      cnt = lim;
      wrap = 1'b1;
    end else cnt = inc ? cnt + 1 : cnt - 1;
  endtask

  // encoder may hold long or short; the bound covers the slowest case
  task automatic step(input logic f);
    int i;
    rnd = xs(rnd);
    @(posedge clk);
    st <= 1'b1;
    fw <= f;
    hold <= 4'h6 + {1'b0, rnd[2:0]};
    @(posedge clk);
    st <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 32 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 32) hang();
    model(a_pin != pa, a_pin, b_pin);
    exp_q.push_back(cnt);
    pa = a_pin;
    pb = b_pin;
    apb(1'b0, `QPC_ADDR_COUNT, 32'h0);
    chk("count", exp_q.pop_front(), rd);
    chk("flags", {29'h0, dir, dchg, wrap}, {29'h0, dir_o, dchg_o, wrap_o});
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst, en, dir, wrap, dchg, pa, pb} = 7'h40;
    {psel, pen, pwr, st, fw} = 5'h0;
    paddr = 8'h00;
    pwd = 32'h0;
    hold = 4'h6;
    rnd = 32'h00018105;
    {bad_count, n_checks, cnt, maxc} = '0;
    mode = QPC_X4_FREE;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `QPC_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    chk("mapped err", 32'h0, {31'h0, slverr});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, slverr});
    step(1'b1);
    for (int m = 0; m < 4; m++) begin
      mv = 2'(m);
      mode = qpc_mode_t'(mv);
      en = 1'b1;
      apb(1'b1, `QPC_ADDR_CTRL, {28'h0, mv[1], mv, 1'b1});
      apb(1'b0, `QPC_ADDR_COUNT, 32'h0);
      chk("count kept", cnt, rd);
      maxc = 3;
      cnt = mode[1] ? 0 : 65532;
      apb(1'b1, `QPC_ADDR_MAXC, maxc);
      apb(1'b1, `QPC_ADDR_COUNT, cnt);
      repeat (10) step(1'b1);
      repeat (10) step(1'b0);
      repeat (12) step(rnd[9]);
      apb(1'b1, `QPC_ADDR_STATUS, 32'h3);
      wrap = 1'b0;
      dchg = 1'b0;
      apb(1'b0, `QPC_ADDR_STATUS, 32'h0);
      chk("status", {29'h0, dir, 2'b00}, rd);
    end
    apb(1'b0, `QPC_ADDR_LATCH, 32'h0);
    chk("latch", cnt, rd);
    tally_and_finish();
  end
endmodule // qpc_tb_top
